// file: rtl/adc_serial_readout_control.sv
// conversion sequencing and serial readout of a 16-bit converter
// assumes chip select and sck arrive asynchronously from a host controller,
// and that the converter core delivers results into the buffer below
`include "adc_readout_consts.svh"

module result_fifo #(
  parameter int unsigned WIDTH = `RES_BITS,
  parameter int unsigned DEPTH = `FIFO_DEPTH
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  wire  [AW:0]      next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // flags are registered so the ready seen by the source is a flop
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= ptr_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      count       <= next_count;
      in_ready_o  <= (next_count != (AW+1)'(DEPTH));
      out_valid_o <= (next_count != '0);
    end
  end
endmodule : result_fifo

// Notes on behaviour
// R1 - sck high, select low: sdo high while converting, low when asleep.
// R2 - conversion lasts a fixed 16.6 ms, never beyond 23 ms; here it stretches while no core result is queued.
// R3 - works with sck idling high or idling low.
// R4 - after sixteenth bit, select rise or sck fall starts conversion.
// R5 - select rise during data output drops remaining bits, starts conversion.
// R6 - host polls status only with sck idling high.
// R7 - after conversion, sleep and hold result until readout begins.
// R8 - sck idling high: seventeenth falling edge starts a conversion.
// R9 - sck idling low: sixteenth falling edge starts a conversion.
// R10 - sck low: select low shows sign bit; select rise restarts.
// R11 - host keeps sck quiet during conversion after an abort.
// R12 - two-wire: select tied low, no abort, no real sleep saving.
// R13 - two-wire idle high: sdo falls at end, 16 read, 17th restarts.
// R14 - two-wire idle low: straight to data output, sixteenth fall restarts.
// R15 - three-wire link gives status, readout and conversion start.
// R16 - next bit after each sck falling edge, msb first.
// R17 - sleep until select and sck both low, then data output.
// R18 - result is 16-bit offset binary, msb set for non-negative input.
// R19 - reset clears registers and starts a conversion.
// R20 - select and sck synchronised before their edges are used.
module adc_serial_readout_control
  import adc_readout_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `CONV_TIME_NS / `CLK_PERIOD_NS,
  parameter int unsigned FIFO_DEPTH  = `FIFO_DEPTH
) (
  input  wire logic                    sys_clk_i,
  input  wire logic                    srst_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    sck_i,
  output logic                         sdo_o,
  output logic                         sdo_oe_o,
  output logic                         sleep_o,
  input  wire adc_readout_pkg::result_t res_data_i,
  input  wire logic                    res_valid_i,
  output logic                         res_ready_o
);
  import adc_readout_pkg::*;

  default clocking main_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  localparam int unsigned CONV_MAX_CYCLES = `CONV_MAX_NS / `CLK_PERIOD_NS;
  localparam logic [`CONV_CNT_W-1:0] CONV_LAST =
    `CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [`BIT_CNT_W-1:0] BIT_LAST = `BIT_CNT_W'(`RES_LAST_BIT);

  conv_state_e             state;
  conv_state_e             next_state;
  logic [2:0]              cs_sync;
  logic [2:0]              sck_sync;
  logic [`CONV_CNT_W-1:0]  conv_cnt;
  logic [`BIT_CNT_W-1:0]   bit_cnt;
  result_t                 shreg;
  result_t                 fifo_data;
  logic                    fifo_valid;
  logic                    next_sdo;

  // stage 0 feeds only stage 1; edges are taken between stages 1 and 2
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cs_sync  <= 3'h7;
      sck_sync <= 3'h0;
    end else begin
      cs_sync  <= {cs_sync[1:0], cs_n_i};   // [R20]
      sck_sync <= {sck_sync[1:0], sck_i};   // [R20]
    end
  end

  wire cs_low   = ~cs_sync[1];
  wire sck_low  = ~sck_sync[1];
  wire cs_rise  = cs_sync[1] & ~cs_sync[2];
  wire sck_fall = ~sck_sync[1] & sck_sync[2];
  wire conv_done = (conv_cnt == CONV_LAST);
  // a finished conversion waits for a core result; the core stalls on ready
  wire take     = (state == ST_CONVERT) & conv_done & fifo_valid;
  wire in_out   = (state == ST_DATA_OUT);
  wire last_fall = in_out & sck_fall & (bit_cnt == BIT_LAST);
  wire shift    = in_out & sck_fall & (bit_cnt != BIT_LAST);
  wire restart  = in_out & (cs_rise | last_fall);   // [R4] [R5] [R12]
  wire wake     = (state == ST_SLEEP) & cs_low & sck_low;   // [R17]
  wire result_sign_bit = shreg[`RES_LAST_BIT];

  result_fifo #(
    .WIDTH (`RES_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .in_data_i   (res_data_i),
    .in_valid_i  (res_valid_i),
    .in_ready_o  (res_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (take)
  );

  // one falling-edge counter covers both clock polarities: with sck idling
  // high the first fall is spent leaving sleep, so the 17th restarts
  always_comb begin
    next_state = state;
    case (state)
      ST_CONVERT:  next_state = take ? ST_SLEEP : ST_CONVERT;   // [R7]
      ST_SLEEP:    next_state = wake ? ST_DATA_OUT : ST_SLEEP;  // [R14]
      ST_DATA_OUT: next_state = restart ? ST_CONVERT : ST_DATA_OUT; // [R8] [R9]
      default:     next_state = ST_CONVERT;
    endcase
  end

  // status in convert/sleep, data in output state; high-z when deselected
  always_comb begin
    case (state)
      ST_CONVERT:  next_sdo = 1'b1;             // [R1] [R15]
      ST_SLEEP:    next_sdo = 1'b0;             // [R1] [R13]
      ST_DATA_OUT: next_sdo = result_sign_bit;  // [R16] [R10]
      default:     next_sdo = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= ST_CONVERT;   // [R19]
    end else begin
      state <= next_state;
    end
  end

  // conversion lasts CONV_CYCLES only if a core result is queued; it stretches while none is   [R2]
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || restart) begin
      conv_cnt <= '0;
    end else if (state == ST_CONVERT && !conv_done) begin
      conv_cnt <= conv_cnt + `CONV_CNT_W'(1);
    end
  end

  // result held as delivered: offset binary, msb first   [R18]
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      shreg   <= '0;
      bit_cnt <= '0;
    end else if (take) begin
      shreg   <= fifo_data;
      bit_cnt <= '0;
    end else if (restart) begin
      shreg   <= '0;   // [R5]
      bit_cnt <= '0;
    end else if (shift) begin
      shreg   <= {shreg[`RES_LAST_BIT-1:0], 1'b0};   // [R16]
      bit_cnt <= bit_cnt + `BIT_CNT_W'(1);
    end
  end

  // sdo follows the synchronised select and sck, so it works at either
  // idle level of sck; the cost is a few system cycles of latency   [R3]
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sdo_o    <= `SDO_RESET;
      sdo_oe_o <= 1'b0;
      sleep_o  <= 1'b0;
    end else begin
      sdo_o    <= next_sdo;
      sdo_oe_o <= cs_low;
      sleep_o  <= (next_state == ST_SLEEP) & ~cs_low;   // [R7]
    end
  end

  // helper: cycles spent in one conversion, including waits for the core
  logic [`CONV_CNT_W:0] conv_age;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || state != ST_CONVERT) begin
      conv_age <= '0;
    end else if (conv_age != '1) begin
      conv_age <= conv_age + (`CONV_CNT_W+1)'(1);
    end
  end

  AST_SDO_BUSY: assert property ( // [R1]
    (state == ST_CONVERT) && cs_low |=> sdo_o && sdo_oe_o)
    else $error("sdo not high while converting");

  AST_SDO_DONE: assert property ( // [R7]
    (state == ST_SLEEP) && cs_low && !wake |=> !sdo_o ##1 !sdo_o || !cs_low)
    else $error("sdo not low while asleep");

  AST_CONV_TIME: assert property ( // [R2]
    take |-> conv_age >= (`CONV_CNT_W+1)'(CONV_CYCLES - 1) &&
             conv_age <  (`CONV_CNT_W+1)'(CONV_MAX_CYCLES))
    else $error("conversion time out of range");

  AST_ABORT: assert property ( // [R5]
    in_out && cs_rise |=> state == ST_CONVERT && conv_cnt == '0 &&
                          shreg == '0)
    else $error("select rise did not abort readout");

  AST_LAST_FALL: assert property ( // [R9]
    in_out && sck_fall && bit_cnt == BIT_LAST |=> state == ST_CONVERT)
    else $error("final falling edge did not restart");

  AST_SIGN_FIRST: assert property ( // [R10]
    $rose(state == ST_DATA_OUT) |=> sdo_o == $past(result_sign_bit))
    else $error("sign bit not presented first");

  // sdo is registered from shreg, so the new bit shows two edges on
  AST_SHIFT: assert property ( // [R16]
    shift && !cs_rise |=> bit_cnt == $past(bit_cnt) + `BIT_CNT_W'(1) ##1
      sdo_o == $past(shreg[`RES_LAST_BIT-1], 2) || !in_out)
    else $error("bit not advanced on falling edge");

  AST_WAKE: assert property ( // [R17]
    (state == ST_SLEEP) && !(cs_low && sck_low) |=> state != ST_DATA_OUT)
    else $error("left sleep without select and sck low");

  AST_RESET: assert property ( // [R19]
    $fell(srst_i) |-> state == ST_CONVERT && conv_cnt == '0 && !sdo_oe_o)
    else $error("reset did not start a conversion");

  AST_SYNC: assert property ( // [R20]
    sck_fall |-> $past(sck_i, 3) && !$past(sck_i, 2))
    else $error("sck edge not taken through synchroniser");

  AST_SLEEP_PIN: assert property ( // [R7]
    (state == ST_SLEEP) && !cs_low |=> sleep_o)
    else $error("sleep output low while asleep and deselected");

  AST_HOLD: assert property ( // [R7]
    (state == ST_SLEEP) |=> shreg == $past(shreg))
    else $error("result changed while asleep");

  AST_LOAD: assert property ( // [R18]
    take |=> shreg == $past(fifo_data))
    else $error("result not loaded as delivered");

  AST_WAKE_LOW: assert property ( // [R14]
    (state == ST_SLEEP) && cs_low && sck_low |=> state == ST_DATA_OUT)
    else $error("select and sck low did not start data output");

  AST_RESTART: assert property ( // [R4]
    restart |=> bit_cnt == '0 && conv_cnt == '0)
    else $error("restart did not clear counters");
endmodule : adc_serial_readout_control

// file: rtl/adc_readout_consts.svh
// timing and format constants for the serial readout controller
// assumes a 250 MHz system clock; included by the package and the design
`ifndef ADC_READOUT_CONSTS_SVH
`define ADC_READOUT_CONSTS_SVH
`define CLK_PERIOD_NS   4
`define CONV_TIME_NS    16600000
`define CONV_MAX_NS     23000000
`define RES_BITS        16
`define RES_LAST_BIT    15
`define FIFO_DEPTH      8
`define CONV_CNT_W      23
`define BIT_CNT_W       4
`define SDO_RESET       1'b1
`endif

// file: rtl/adc_readout_pkg.sv
// types shared by the readout controller
// assumes the constants header is on the include path
`include "adc_readout_consts.svh"
package adc_readout_pkg;
  typedef enum logic [1:0] {
    ST_CONVERT  = 2'b00,
    ST_SLEEP    = 2'b01,
    ST_DATA_OUT = 2'b10
  } conv_state_e;
  typedef logic [`RES_BITS-1:0] result_t;
endpackage : adc_readout_pkg

// file: dv/host_spi_model.sv
// host-side serial controller model driving chip select and serial clock
// assumes the device updates sdo well within one 40 ns half period
module host_spi_model (
  input  wire logic sdo_i,
  output logic      cs_n_o,
  output logic      sck_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n_o = 1'b1;
    sck_o  = 1'b0;
  end

  // status look needs sck high; with sck low the pin shows data instead
  task automatic poll(output logic st);
    sck_o  = 1'b1;
    cs_n_o = 1'b0;
    #40;
    st     = sdo_i;
    cs_n_o = 1'b1;
    #40;
  endtask : poll

  // nb bits sampled on sck rise, then restart by sck fall or select rise
  task automatic xfer(input bit cpol, input int nb, input bit sck_end,
                      input bit hold_cs, output logic [15:0] w,
                      output logic first);
    w      = '0;
    sck_o  = cpol;
    cs_n_o = 1'b0;
    #40;
    first  = sdo_i;
    for (int i = 0; i < nb; i++) begin
      sck_o = 1'b0;
      #40;
      sck_o = 1'b1;
      w     = {w[14:0], sdo_i};
      #40;
    end
    if (sck_end) begin
      sck_o = 1'b0;
      #40;
    end
    if (!hold_cs) begin
      cs_n_o = 1'b1;
    end
    #40;
    // one return to idle only, to keep the converter quiet
    sck_o = cpol;
    #40;
  endtask : xfer
endmodule : host_spi_model

// file: dv/tb.sv
// self-checking bench for the serial readout controller
// assumes the design files and the host model are compiled before it
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_readout_pkg::*;
  // short conversion so the run stays brief
  localparam int unsigned CONV = 100;
  logic    sys_clk_i = 1'b0;
  logic    srst_i = 1'b1;
  logic    res_valid = 1'b0;
  result_t res_data = '0;
  logic    cs_n, sck, sdo, sdo_oe, sleep, res_ready;
  result_t exp_q[$];
  result_t pat[8] = '{16'hffff, 16'h0000, 16'h8000, 16'h7fff,
                      16'ha5c3, 16'h5a3c, 16'h0001, 16'hfffe};
  int      num_errors = 0;
  int      checks_done = 0;

  always #2 sys_clk_i = ~sys_clk_i;

  adc_serial_readout_control #(.CONV_CYCLES(CONV), .FIFO_DEPTH(8)) u_dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .sleep_o(sleep),
    .res_data_i(res_data), .res_valid_i(res_valid),
    .res_ready_o(res_ready));
  host_spi_model u_host (.sdo_i(sdo), .cs_n_o(cs_n), .sck_o(sck));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // one extra word for the conversion that follows a two-wire restart
  task automatic push_word(input result_t d);
    @(negedge sys_clk_i);
    chk(res_ready, 1'b1);
    res_valid = 1'b1;
    res_data  = d;
    exp_q.push_back(d);
    @(negedge sys_clk_i);
    res_valid = 1'b0;
  endtask : push_word

  // ready is sampled at the falling edge, where it is settled
  task automatic t_fill();
    int acc;
    acc = 0;
    for (int i = 0; i < 9; i++) begin
      @(negedge sys_clk_i);
      if (res_ready === 1'b1) begin
        exp_q.push_back(pat[i % 8]);
        acc++;
      end
      res_valid = 1'b1;
      res_data  = pat[i % 8];
    end
    @(negedge sys_clk_i);
    res_valid = 1'b0;
    chk(16'(acc), 16'h0008);
    chk(res_ready, 1'b0);
    $display("fill done");
  endtask : t_fill

  task automatic t_status();
    logic st;
    u_host.poll(st);
    chk(st, 1'b1);
    #(CONV * 4 + 200);
    u_host.poll(st);
    chk(st, 1'b0);
    chk(sleep, 1'b1);
    $display("status done");
  endtask : t_status

  task automatic t_read(input bit cpol, input bit sck_end);
    logic [15:0] w;
    logic        f, st;
    u_host.xfer(cpol, 16, sck_end, 1'b0, w, f);
    chk(w, exp_q.pop_front());
    u_host.poll(st);
    chk(st, 1'b1);
    #(CONV * 4 + 200);
    $display("read cpol=%0d sck_end=%0d done", cpol, sck_end);
  endtask : t_read

  task automatic t_abort();
    logic [15:0] w, e;
    logic        f, st;
    e = exp_q.pop_front();
    u_host.xfer(1'b0, 5, 1'b0, 1'b0, w, f);
    chk(w[4:0], e[15:11]);
    u_host.poll(st);
    chk(st, 1'b1);
    #(CONV * 4 + 200);
    e = exp_q.pop_front();
    u_host.xfer(1'b0, 0, 1'b0, 1'b0, w, f);
    chk(f, e[15]);
    u_host.poll(st);
    chk(st, 1'b1);
    #(CONV * 4 + 200);
    $display("abort done");
  endtask : t_abort

  task automatic t_two_wire();
    logic [15:0] w, e;
    logic        f;
    int          n;
    e = exp_q.pop_front();
    u_host.xfer(1'b1, 16, 1'b1, 1'b1, w, f);
    chk(f, 1'b0);
    chk(w, e);
    chk(sdo, 1'b1);
    chk(sdo_oe, 1'b1);
    n = 0;
    while (sdo !== 1'b0 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(16'((n >= CONV - 40) && (n <= CONV)), 16'h0001);
    push_word(16'h63c9);
    e = exp_q.pop_front();
    u_host.xfer(1'b0, 16, 1'b1, 1'b1, w, f);
    chk(f, e[15]);
    chk(w, e);
    chk(sdo, 1'b1);
    // select and sck stay low: the result must appear with no clocking
    #(CONV * 4 + 200);
    e = exp_q.pop_front();
    chk(sdo, e[15]);
    u_host.xfer(1'b0, 16, 1'b1, 1'b1, w, f);
    chk(w, e);
    chk(sdo, 1'b1);
    $display("two wire done");
  endtask : t_two_wire

  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    srst_i = 1'b0;
    chk(sdo, 1'b1);
    chk(sdo_oe, 1'b0);
    t_fill();
    t_status();
    t_read(1'b1, 1'b1);
    t_read(1'b1, 1'b0);
    t_read(1'b0, 1'b1);
    t_read(1'b0, 1'b0);
    t_abort();
    t_two_wire();
    print_verdict();
  end
endmodule : tb
